// *** adc_output_config_regs.sv ***
// Output path configuration registers and the data formatting they steer.
// Assumes the serial port logic delivers decoded byte writes and reads
// on mclk_i, and the divider phase count comes from the same clock.
//
// What this block does
// - The offset trim is a signed value from +127 to -128 codes added to each sample.
// - The trim uses all eight bits and only changes when this channel is addressed.
// - Format code 00 puts samples out as offset binary words.
// - The fine delay setting only moves output launch timing, never internal sampling.
`timescale 1ns/1ps
module adc_output_config_regs
  import adc_cfg_pkg::*;
(
  input  wire logic                mclk_i,
  input  wire logic                rst_i,
  input  wire reg_req_type         req_i,
  input  wire logic [7:0]          rd_addr_i,
  output logic      [7:0]          rd_data_o,
  output logic                     rd_hit_o,
  input  wire logic [SAMPLE_W-1:0] sample_i,
  input  wire logic [2:0]          div_phase_i,
  output logic      [SAMPLE_W-1:0] data_o,
  output logic                     data_oe_o,
  output logic                     data_clock_output_o,
  output delay_ctrl_type           delay_ctrl_o,
  output logic      [7:0]          drive_str_o,
  output logic      [2:0]          ref_span_o,
  output logic      [1:0]          io_level_o
);

  // ==========================================================
  // Register file
  logic [7:0] offset_trim_ff;
  logic [7:0] format_ctrl_ff;
  logic [7:0] drive_str_ff;
  logic [7:0] clock_phase_ff;
  logic [7:0] fine_delay_ff;
  logic [7:0] ref_span_ff;

  // ==========================================================
  // Write decode
  // One strobe per register, so each update block keeps to one concern
  logic wr_trim;
  logic wr_format;
  logic wr_drive;
  logic wr_phase;
  logic wr_delay;
  logic wr_span;

  assign wr_trim   = req_i.wr && req_i.local_sel &&
                     (req_i.addr == ADDR_OFFSET_TRIM);
  assign wr_format = req_i.wr && (req_i.addr == ADDR_FORMAT_CTRL);
  assign wr_drive  = req_i.wr && (req_i.addr == ADDR_DRIVE_STR);
  assign wr_phase  = req_i.wr && (req_i.addr == ADDR_CLOCK_PHASE);
  assign wr_delay  = req_i.wr && (req_i.addr == ADDR_FINE_DELAY);
  assign wr_span   = req_i.wr && (req_i.addr == ADDR_REF_SPAN);

  // Offset is per channel, so it ignores writes aimed elsewhere
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      offset_trim_ff <= RST_OFFSET_TRIM;
    else if (wr_trim)
      offset_trim_ff <= req_i.wdata;
  end

  // Whole-byte registers: every bit is host writable
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      format_ctrl_ff <= RST_FORMAT_CTRL;
    else if (wr_format)
      format_ctrl_ff <= req_i.wdata;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      drive_str_ff <= RST_DRIVE_STR;
    else if (wr_drive)
      drive_str_ff <= req_i.wdata;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      clock_phase_ff <= RST_CLOCK_PHASE;
    else if (wr_phase)
      clock_phase_ff <= req_i.wdata;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      fine_delay_ff <= RST_FINE_DELAY;
    else if (wr_delay)
      fine_delay_ff <= req_i.wdata;
  end

  // Fixed upper bits survive any write
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      ref_span_ff <= RST_REF_SPAN;
    else if (wr_span)
      ref_span_ff <= (ref_span_ff & ~REF_SPAN_WMASK) |
                     (req_i.wdata & REF_SPAN_WMASK);
  end

  // ==========================================================
  // Read back
  always_comb
  begin
    rd_hit_o  = 1'b1;
    unique case (rd_addr_i)
      ADDR_OFFSET_TRIM: rd_data_o = offset_trim_ff;
      ADDR_FORMAT_CTRL: rd_data_o = format_ctrl_ff;
      ADDR_DRIVE_STR:   rd_data_o = drive_str_ff;
      ADDR_CLOCK_PHASE: rd_data_o = clock_phase_ff;
      ADDR_FINE_DELAY:  rd_data_o = fine_delay_ff;
      ADDR_REF_SPAN:    rd_data_o = ref_span_ff;
      default:
      begin
        rd_data_o = 8'h00;
        rd_hit_o  = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Offset trim with saturation
  logic signed [SAMPLE_W+1:0] trim_ext;
  logic signed [SAMPLE_W+1:0] sum_s;
  logic        [SAMPLE_W-1:0] trimmed;

  // Two guard bits hold both overflow and underflow of the sum
  assign trim_ext = $signed({{(SAMPLE_W+2-TRIM_W){offset_trim_ff[TRIM_W-1]}},
                             offset_trim_ff});

  // Saturate rather than wrap, so a large trim never folds full scale over
  always_comb
  begin
    sum_s = $signed({2'b00, sample_i}) + trim_ext;
    if (sum_s < 0)
      trimmed = CODE_MIN;
    else if (sum_s > $signed({2'b00, CODE_MAX}))
      trimmed = CODE_MAX;
    else
      trimmed = sum_s[SAMPLE_W-1:0];
  end

  // ==========================================================
  // Output coding
  logic [1:0]          fmt_code;
  logic [SAMPLE_W-1:0] coded;
  logic [SAMPLE_W-1:0] nxt_word;

  logic                invert_en;
  logic                out_enable;

  assign fmt_code   = format_ctrl_ff[FMT_CODE_HI:FMT_CODE_LO];
  assign invert_en  = format_ctrl_ff[FMT_INVERT_BIT];
  // Register bit disables; the launch stage wants an enable
  assign out_enable = ~format_ctrl_ff[FMT_DISABLE_BIT];

  always_comb
  begin
    unique case (fmt_code)
      FMT_OFFSET_BIN: coded = trimmed;
      FMT_TWOS_COMP:  coded = trimmed ^ MSB_MASK;
      FMT_GRAY:       coded = trimmed ^ (trimmed >> 1);
      default:        coded = trimmed; // Reserved code falls back
    endcase
    nxt_word = invert_en ? ~coded : coded;
  end

  launch_stage u_launch
  (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .word_i (nxt_word),
    .oe_i   (out_enable),
    .word_o (data_o),
    .oe_o   (data_oe_o)
  );

  // ==========================================================
  // Data clock output
  logic       dco_ff;
  logic [2:0] phase_sel;
  logic       dco_pol;
  logic       phase_match;

  assign phase_sel   = clock_phase_ff[PHASE_SEL_HI:PHASE_SEL_LO];
  assign dco_pol     = clock_phase_ff[PHASE_POL_BIT];
  assign phase_match = (div_phase_i == phase_sel);

  // High for the selected divider phase only; polarity applied after.
  // Registered so the pin never sees a glitch from the phase compare.
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      dco_ff <= 1'b0;
    else
      dco_ff <= phase_match ^ dco_pol;
  end

  assign data_clock_output_o = dco_ff;

  // ==========================================================
  // Launch delay taps
  // Taps go to the pad delay cells only; the sample path never sees them
  assign delay_ctrl_o.sel     = fine_delay_ff[DLY_SEL_HI:DLY_SEL_LO];
  assign delay_ctrl_o.dco_en  = fine_delay_ff[DLY_DCO_EN_BIT];
  assign delay_ctrl_o.data_en = fine_delay_ff[DLY_DATA_EN_BIT];

  // ==========================================================
  // Pad settings
  // Passed straight through; their analog meaning lives in the pads
  assign drive_str_o = drive_str_ff;
  assign ref_span_o  = ref_span_ff[SPAN_SEL_HI:SPAN_SEL_LO];
  assign io_level_o  = format_ctrl_ff[IO_LEVEL_HI:IO_LEVEL_LO];

endmodule

// *** adc_cfg_pkg.sv ***
// Constants and types shared by the output configuration register bank.
// Assumes a single sample clock domain and a byte-wide register port.
package adc_cfg_pkg;

  // ==========================================================
  // Register addresses
  localparam logic [7:0] ADDR_OFFSET_TRIM   = 8'h10;
  localparam logic [7:0] ADDR_FORMAT_CTRL   = 8'h14;
  localparam logic [7:0] ADDR_DRIVE_STR     = 8'h15;
  localparam logic [7:0] ADDR_CLOCK_PHASE   = 8'h16;
  localparam logic [7:0] ADDR_FINE_DELAY    = 8'h17;
  localparam logic [7:0] ADDR_REF_SPAN      = 8'h18;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_OFFSET_TRIM    = 8'h00;
  localparam logic [7:0] RST_FORMAT_CTRL    = 8'h00;
  localparam logic [7:0] RST_DRIVE_STR      = 8'h22;
  localparam logic [7:0] RST_CLOCK_PHASE    = 8'h00;
  localparam logic [7:0] RST_FINE_DELAY     = 8'h00;
  localparam logic [7:0] RST_REF_SPAN       = 8'hE0;

  // ==========================================================
  // Field layout
  localparam int FMT_CODE_LO    = 0;
  localparam int FMT_CODE_HI    = 1;
  localparam int FMT_INVERT_BIT = 2;
  localparam int FMT_DISABLE_BIT = 4;
  localparam int PHASE_POL_BIT  = 7;
  localparam int PHASE_SEL_LO   = 0;
  localparam int PHASE_SEL_HI   = 2;
  localparam int DLY_SEL_LO     = 0;
  localparam int DLY_SEL_HI     = 2;
  localparam int DLY_DATA_EN_BIT = 5;
  localparam int DLY_DCO_EN_BIT = 7;
  localparam int IO_LEVEL_LO    = 6;
  localparam int IO_LEVEL_HI    = 7;
  localparam int SPAN_SEL_LO    = 0;
  localparam int SPAN_SEL_HI    = 2;
  // Only the span code is writable; upper bits are fixed
  localparam logic [7:0] REF_SPAN_WMASK = 8'h07;

  localparam logic [1:0] FMT_OFFSET_BIN = 2'h0;
  localparam logic [1:0] FMT_TWOS_COMP  = 2'h1;
  localparam logic [1:0] FMT_GRAY       = 2'h2;

  // ==========================================================
  // Sample path
  localparam int SAMPLE_W = 10;
  localparam int TRIM_W   = 8;
  localparam logic [SAMPLE_W-1:0] CODE_MAX = 10'h3FF;
  localparam logic [SAMPLE_W-1:0] CODE_MIN = 10'h000;
  localparam logic [SAMPLE_W-1:0] MSB_MASK = 10'h200;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       local_sel;
  } reg_req_type;

  typedef struct packed {
    logic [2:0] sel;
    logic       dco_en;
    logic       data_en;
  } delay_ctrl_type;

endpackage

// *** launch_stage.sv ***
// Output launch register: holds the data word and its enable.
// Assumes inputs come from logic on the same clock.
`timescale 1ns/1ps
module launch_stage
  import adc_cfg_pkg::*;
(
  input  wire logic                mclk_i,
  input  wire logic                rst_i,
  input  wire logic [SAMPLE_W-1:0] word_i,
  input  wire logic                oe_i,
  output logic      [SAMPLE_W-1:0] word_o,
  output logic                     oe_o
);

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      word_o <= CODE_MIN;
      oe_o   <= 1'b0;
    end
    else
    begin
      word_o <= word_i;
      oe_o   <= oe_i;
    end
  end

endmodule

// *** cfg_host_model.sv ***
// Host model: hands decoded byte writes to the register bank.
// Assumes the bench calls wr and the bank samples on posedge.
`timescale 1ns/1ps
module cfg_host_model
  import adc_cfg_pkg::*;
(
  input  wire logic  mclk_i,
  output reg_req_type req_o
);
  initial req_o = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic l);
    @(negedge mclk_i);
    req_o = '{addr: a, wdata: d, wr: 1'b1, local_sel: l};
    @(negedge mclk_i);
    req_o.wr = 1'b0;
    // Stale byte would hide a missing strobe check
    req_o.wdata = ~d;
  endtask
endmodule

// *** cfg_checker.sv ***
// Port assertions for the output configuration bank.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module cfg_checker
  import adc_cfg_pkg::*;
(
  input wire logic           mclk_i,
  input wire logic           rst_i,
  input wire reg_req_type    req_i,
  input wire logic [7:0]     rd_addr_i,
  input wire logic [7:0]     rd_data_o,
  input wire logic           rd_hit_o,
  input wire logic [2:0]     div_phase_i,
  input wire logic [9:0]     data_o,
  input wire logic           data_oe_o,
  input wire logic           data_clock_output_o,
  input wire delay_ctrl_type delay_ctrl_o,
  input wire logic [7:0]     drive_str_o,
  input wire logic [2:0]     ref_span_o,
  input wire logic [1:0]     io_level_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence trim_wr(l);
    req_i.wr && req_i.addr == 8'h10 && req_i.local_sel == l
      && rd_addr_i == 8'h10;
  endsequence
  trim_load_a: assert property (trim_wr(1) ##1 rd_addr_i == 8'h10
    |-> rd_data_o == $past(req_i.wdata)) else $error("trim not loaded");
  trim_local_a: assert property (trim_wr(0) ##1 rd_addr_i == 8'h10
    |-> $stable(rd_data_o)) else $error("trim took foreign write");
  delay_taps_a: assert property (req_i.wr && req_i.addr == 8'h17 |=>
    delay_ctrl_o == {$past(req_i.wdata[2:0]), $past(req_i.wdata[7]),
    $past(req_i.wdata[5])}) else $error("delay taps wrong");
  dco_phase_a: assert property (rd_addr_i == 8'h16 |=>
    data_clock_output_o == (($past(div_phase_i) == $past(rd_data_o[2:0]))
    ^ $past(rd_data_o[7]))) else $error("data clock phase wrong");
  drive_write_a: assert property (req_i.wr && req_i.addr == 8'h15 |=>
    drive_str_o == $past(req_i.wdata)) else $error("drive not written");
  span_mask_a: assert property (req_i.wr && req_i.addr == 8'h18 |=>
    ref_span_o == $past(req_i.wdata[2:0])) else $error("span wrong");
  io_level_a: assert property (req_i.wr && req_i.addr == 8'h14 |=>
    io_level_o == $past(req_i.wdata[7:6])) else $error("io level wrong");
  unmapped_zero_a: assert property (!rd_hit_o |-> rd_data_o == 8'h00)
    else $error("unmapped read not zero");
  reset_quiet_a: assert property (disable iff (1'b0) rst_i |=>
    !data_oe_o && data_o == 10'h000) else $error("outputs live in reset");
endmodule
bind adc_output_config_regs cfg_checker chk (.mclk_i, .rst_i, .req_i,
  .rd_addr_i, .rd_data_o, .rd_hit_o, .div_phase_i, .data_o, .data_oe_o,
  .data_clock_output_o, .delay_ctrl_o, .drive_str_o, .ref_span_o,
  .io_level_o);

// *** test_adc_output_config_regs.sv ***
// Self-checking bench for the output configuration bank.
// Assumes cfg_host_model for writes and the bound checker.
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module test_adc_output_config_regs;
  import adc_cfg_pkg::*;
  logic        mclk_i = 0, rst_i = 1;
  logic [7:0]  rd_addr_i = 8'h00, rd_data_o;
  logic [9:0]  sample_i = 10'h000, data_o;
  logic [2:0]  div_phase_i = 3'h0;
  logic        data_oe_o;
  logic [11:0] q [$], e;
  logic [7:0]  tv [2] = '{8'h7F, 8'h80};
  int          failures = 0, total_checks = 0;
  reg_req_type req;
  initial forever #5 mclk_i = ~mclk_i;
  cfg_host_model host (.mclk_i, .req_o(req));
  adc_output_config_regs dut (.mclk_i, .rst_i, .req_i(req), .rd_addr_i,
    .rd_data_o, .rd_hit_o(), .sample_i, .div_phase_i, .data_o,
    .data_oe_o, .data_clock_output_o(), .delay_ctrl_o(), .drive_str_o(),
    .ref_span_o(), .io_level_o());
  function automatic logic [9:0] fmt(logic [9:0] s, logic [7:0] t,
                                     logic [1:0] f);
    int v;
    logic [9:0] w;
    v = int'(s) + int'($signed(t));
    w = v < 0 ? 10'h000 : v > 1023 ? 10'h3FF : 10'(v);
    return f == 2'h1 ? w ^ 10'h200 : f == 2'h2 ? w ^ (w >> 1) : w;
  endfunction
  task automatic rd(logic [7:0] a, logic [7:0] x);
    @(negedge mclk_i);
    rd_addr_i = a;
    q.push_back({4'h8, x});
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // =====================================
  // Result watcher
  always @(posedge mclk_i) begin
    #1;
    if (q.size() > 0) begin
      e = q.pop_front();
      if (e[11]) `CHK(rd_data_o, e[7:0])
      else `CHK({data_oe_o, data_o}, e[10:0])
    end
  end
  initial begin
    repeat (3000) @(posedge mclk_i);
    failures++;
    complete_run();
  end
  // =====================================
  // Stimulus
  initial begin
    void'($urandom(32'h4FD9));
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i) rst_i = 0;
    rd(8'h11, 8'h00);
    rd(8'h14, RST_FORMAT_CTRL);
    rd(8'h17, RST_FINE_DELAY);
    rd(8'h15, RST_DRIVE_STR);
    rd(8'h18, RST_REF_SPAN);
    rd(8'h10, RST_OFFSET_TRIM);
    host.wr(8'h10, 8'h33, 1'b0);
    host.wr(8'h10, 8'h81, 1'b1);
    host.wr(8'h18, 8'hFF, 1'b0);
    host.wr(8'h17, 8'hA5, 1'b0);
    host.wr(8'h11, 8'hFF, 1'b0);
    host.wr(8'h16, 8'h85, 1'b0);
    host.wr(8'h15, 8'h5A, 1'b0);
    rd(8'h10, 8'h81);
    rd(8'h18, 8'hE7);
    rd(8'h11, 8'h00);
    rd(8'h15, 8'h5A);
    rd(8'h17, 8'hA5);
    rd(8'h16, 8'h85);
    // Saturation is reached at both trim extremes
    // Bits of f: format code, invert, then output disable
    foreach (tv[k]) for (int f = 0; f < 16; f++) begin
      host.wr(8'h10, tv[k], 1'b1);
      host.wr(8'h14, {2'($urandom), 1'b0, f[3], 1'b0, 3'(f)}, 1'b0);
      repeat (16) begin
        @(negedge mclk_i);
        sample_i = 10'($urandom);
        div_phase_i = 3'($urandom);
        q.push_back({1'b0, !f[3],
          fmt(sample_i, tv[k], 2'(f)) ^ {SAMPLE_W{f[2]}}});
      end
    end
    @(negedge mclk_i) rst_i = 1;
    @(negedge mclk_i) rst_i = 0;
    rd(8'h16, RST_CLOCK_PHASE);
    repeat (3) @(posedge mclk_i);
    complete_run();
  end
endmodule
